/* common/tmr_pkg.sv */
// package: register map, control field positions and reset values of the timer family
package tmr_pkg;
  localparam int NUM_TMR = 3;
  localparam int IDX_A = 0;
  localparam int IDX_B = 1;
  localparam int IDX_C = 2;
  localparam int DATA_W = 16;
  localparam int TMR_STRIDE = 3;
  localparam int CNT_OFS = 0;
  localparam int PER_OFS = 1;
  localparam int CTL_OFS = 2;
  localparam int IRQ_BASE = 9;
  localparam int RUN_BIT = 15;
  localparam int IDLE_BIT = 13;
  localparam int GATE_BIT = 6;
  localparam int PSC_HI = 5;
  localparam int PSC_LO = 4;
  localparam int PAIR_BIT = 3;
  localparam int SYNC_BIT = 2;
  localparam int TCS_BIT = 1;
  localparam int LPO_BIT = 0;
  localparam int FLAG_BIT = 0;
  localparam int IEN_BIT = 1;
  localparam int PRIO_HI = 6;
  localparam int PRIO_LO = 4;
  localparam logic [15:0] CTL_MASK_A = 16'ha077;
  localparam logic [15:0] CTL_MASK_B = 16'ha07a;
  localparam logic [15:0] CTL_MASK_C = 16'ha072;
  localparam logic [15:0] CTL_RESET = 16'h0000;
  localparam logic [7:0] PSC_MASK_1 = 8'h00;
  localparam logic [7:0] PSC_MASK_8 = 8'h07;
  localparam logic [7:0] PSC_MASK_64 = 8'h3f;
  localparam logic [7:0] PSC_MASK_256 = 8'hff;
  localparam logic [1:0] PSC_DIV1 = 2'h0;
  localparam logic [1:0] PSC_DIV8 = 2'h1;
  localparam logic [1:0] PSC_DIV64 = 2'h2;
  localparam logic [1:0] PSC_DIV256 = 2'h3;
endpackage

/* design/tmr_family.sv */
// design: three 16-bit timers (types a, b, c) with pairing, prescaler, sync and register port
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////////////////////////
module tmr_family import tmr_pkg::*; #(
  parameter int ADDR_W = 5
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_idle,
  input wire logic i_lposc_clk,
  input wire logic [2:0] i_ext_clk,
  output logic [15:0] o_rdata,
  output logic [2:0] o_irq,
  output logic [8:0] o_irq_prio,
  output logic o_adc_trig
);

  if (ADDR_W < 4) begin : g_chk
    $error("ADDR_W too small for the register map");
  end

  typedef struct packed {
    logic [2:0][15:0] count;
    logic [2:0][15:0] period;
    logic [2:0][15:0] ctrl;
    logic [2:0] ien;
    logic [2:0] iflag;
    logic [2:0][2:0] iprio;
    logic [2:0][7:0] psc;
    logic [2:0] raw_q;
    logic [2:0] tgl;
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] irq;
    logic adc;
    logic [15:0] rdata;
  } tmr_state_s;

  tmr_state_s q;
  tmr_state_s n;
  logic [2:0] tick;
  logic [2:0] runok;
  logic [2:0] raw;
  logic match_c;

  function automatic logic [7:0] psc_mask(input logic [1:0] sel);
    logic [7:0] m;
    m = PSC_MASK_1;
    unique case (sel)
      PSC_DIV1: m = PSC_MASK_1;
      PSC_DIV8: m = PSC_MASK_8;
      PSC_DIV64: m = PSC_MASK_64;
      PSC_DIV256: m = PSC_MASK_256;
    endcase
    return m;
  endfunction

  function automatic logic [ADDR_W-1:0] reg_addr(input int base, input int ofs);
    return ADDR_W'(base + ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic ev;
    logic pulse;
    logic synced;
    logic clock_source_select;
    logic pair;
    logic [7:0] msk;
    logic [2:0] hwset;
    logic [31:0] pc;
    logic [15:0] wmask;
    ev = 1'b0;
    pulse = 1'b0;
    synced = 1'b0;
    clock_source_select = 1'b0;
    msk = 8'h00;
    hwset = 3'h0;
    pc = 32'h0;
    wmask = 16'h0000;
    n = q;
    tick = 3'h0;
    runok = 3'h0;
    match_c = 1'b0;
    pair = q.ctrl[IDX_B][PAIR_BIT];
    raw = i_ext_clk;
    if (q.ctrl[IDX_A][LPO_BIT]) begin
      raw[IDX_A] = i_lposc_clk;
    end
    n.raw_q = raw;
    for (int i = 0; i < NUM_TMR; i++) begin
      runok[i] = q.ctrl[i][RUN_BIT] && !(i_idle && q.ctrl[i][IDLE_BIT]);
      if (i == IDX_C && pair) begin
        runok[i] = 1'b0;
      end
      clock_source_select = q.ctrl[i][TCS_BIT];
      if (clock_source_select) begin
        if (i == IDX_C) begin
          ev = q.s2[i] && !q.s3[i];
        end else begin
          ev = raw[i] && !q.raw_q[i];
        end
      end else begin
        ev = q.ctrl[i][GATE_BIT] ? raw[i] : 1'b1;
      end
      msk = psc_mask(q.ctrl[i][PSC_HI:PSC_LO]);
      pulse = runok[i] && ev && ((q.psc[i] & msk) == msk);
      if (!runok[i] || pulse) begin
        n.psc[i] = 8'h00;
      end else if (ev) begin
        n.psc[i] = q.psc[i] + 8'h01;
      end
      n.tgl[i] = q.tgl[i] ^ pulse;
      n.s1[i] = (i == IDX_C) ? raw[i] : q.tgl[i];
      n.s2[i] = q.s1[i];
      n.s3[i] = q.s2[i];
      synced = clock_source_select && ((i == IDX_B) || (i == IDX_A && q.ctrl[IDX_A][SYNC_BIT]));
      tick[i] = synced ? (runok[i] && (q.s2[i] ^ q.s3[i])) : pulse;
      if (tick[i] && !(i == IDX_B && pair)) begin
        if (q.count[i] == q.period[i]) begin
          n.count[i] = 16'h0000;
          hwset[i] = 1'b1;
          if (i == IDX_C) begin
            match_c = 1'b1;
          end
        end else begin
          n.count[i] = q.count[i] + 16'h0001;
        end
      end
    end
    if (pair && tick[IDX_B]) begin
      pc = {q.count[IDX_C], q.count[IDX_B]};
      if (pc == {q.period[IDX_C], q.period[IDX_B]}) begin
        pc = 32'h0;
        hwset[IDX_C] = 1'b1;
        match_c = 1'b1;
      end else begin
        pc = pc + 32'h1;
      end
      n.count[IDX_C] = pc[31:16];
      n.count[IDX_B] = pc[15:0];
    end
    n.iflag = q.iflag | hwset;
    n.adc = match_c;
    n.rdata = 16'h0000;
    for (int i = 0; i < NUM_TMR; i++) begin
      wmask = (i == IDX_A) ? CTL_MASK_A : ((i == IDX_B) ? CTL_MASK_B : CTL_MASK_C);
      if (i_wr) begin
        if (i_addr == reg_addr(TMR_STRIDE * i, CNT_OFS)) begin
          n.count[i] = i_wdata;
        end
        if (i_addr == reg_addr(TMR_STRIDE * i, PER_OFS)) begin
          n.period[i] = i_wdata;
        end
        if (i_addr == reg_addr(TMR_STRIDE * i, CTL_OFS)) begin
          n.ctrl[i] = i_wdata & wmask;
        end
        if (i_addr == reg_addr(IRQ_BASE, i)) begin
          n.iflag[i] = i_wdata[FLAG_BIT] | hwset[i];
          n.ien[i] = i_wdata[IEN_BIT];
          n.iprio[i] = i_wdata[PRIO_HI:PRIO_LO];
        end
      end
      if (i_rd) begin
        if (i_addr == reg_addr(TMR_STRIDE * i, CNT_OFS)) begin
          n.rdata = q.count[i];
        end
        if (i_addr == reg_addr(TMR_STRIDE * i, PER_OFS)) begin
          n.rdata = q.period[i];
        end
        if (i_addr == reg_addr(TMR_STRIDE * i, CTL_OFS)) begin
          n.rdata = q.ctrl[i];
        end
        if (i_addr == reg_addr(IRQ_BASE, i)) begin
          n.rdata[FLAG_BIT] = q.iflag[i];
          n.rdata[IEN_BIT] = q.ien[i];
          n.rdata[PRIO_HI:PRIO_LO] = q.iprio[i];
        end
      end
    end
    n.irq = n.iflag & n.ien;
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign o_rdata = q.rdata;
  assign o_irq = q.irq;
  assign o_irq_prio = q.iprio;
  assign o_adc_trig = q.adc;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  a_wrap_flag: assert property (
    tick[IDX_A] && q.count[IDX_A] == q.period[IDX_A] && !i_wr
    |=> q.count[IDX_A] == 16'h0000 && q.iflag[IDX_A] ##1 o_irq[IDX_A] == q.ien[IDX_A])
    else $error("timer a did not wrap and flag at period");

  a_count_step: assert property (
    tick[IDX_A] && q.count[IDX_A] != q.period[IDX_A] && !i_wr
    |=> q.count[IDX_A] == $past(q.count[IDX_A]) + 16'h0001)
    else $error("timer a did not step on a tick");

  a_div_eight: assert property (
    runok[IDX_B] && !q.ctrl[IDX_B][TCS_BIT] && !q.ctrl[IDX_B][GATE_BIT]
    && q.ctrl[IDX_B][PSC_HI:PSC_LO] == PSC_DIV8 && tick[IDX_B] && !i_wr
    |=> !tick[IDX_B] [*7] ##1 tick[IDX_B] || $changed(q.ctrl[IDX_B]) || i_idle)
    else $error("divide by eight spacing wrong");

  a_idle_halt: assert property (
    i_idle && q.ctrl[IDX_A][IDLE_BIT] |-> !tick[IDX_A] && !runok[IDX_A])
    else $error("timer a ticked while halted in idle");

  a_stop_hold: assert property (
    !q.ctrl[IDX_C][RUN_BIT] && !q.ctrl[IDX_B][PAIR_BIT] && !i_wr
    |=> $stable(q.count[IDX_C]))
    else $error("stopped timer c changed its count");

  a_reset_ctrl: assert property (
    $past(i_rst) |-> q.ctrl == '0 && o_irq == 3'h0 && !o_adc_trig)
    else $error("control not cleared by reset");

  a_adc_pulse: assert property (
    match_c |=> o_adc_trig ##1 !o_adc_trig || $past(match_c))
    else $error("conversion trigger missing after type c match");

  a_flag_hold: assert property (
    q.iflag[IDX_B] && !i_wr |=> q.iflag[IDX_B])
    else $error("flag dropped without a software clear");

  a_read_data: assert property (
    i_rd && i_addr == reg_addr(TMR_STRIDE * IDX_C, PER_OFS)
    |=> o_rdata == $past(q.period[IDX_C]))
    else $error("period read returned wrong data");

  a_pair_carry: assert property (
    q.ctrl[IDX_B][PAIR_BIT] && tick[IDX_B] && q.count[IDX_B] == 16'hffff
    && q.count[IDX_C] != q.period[IDX_C] && !i_wr
    |=> q.count[IDX_B] == 16'h0000 && q.count[IDX_C] == $past(q.count[IDX_C]) + 16'h0001)
    else $error("32-bit pair failed to carry");

  a_c_presync: assert property (
    q.ctrl[IDX_C][TCS_BIT] && runok[IDX_C] && q.ctrl[IDX_C][PSC_HI:PSC_LO] == PSC_DIV1
    && $rose(q.s2[IDX_C]) |-> tick[IDX_C])
    else $error("type c missed a synchronised edge");

  a_a_nosync: assert property (
    q.ctrl[IDX_A][TCS_BIT] && !q.ctrl[IDX_A][SYNC_BIT] && runok[IDX_A]
    && q.ctrl[IDX_A][PSC_HI:PSC_LO] == PSC_DIV1 && raw[IDX_A] && !q.raw_q[IDX_A]
    |-> tick[IDX_A])
    else $error("type a async mode missed an edge");

  a_a_postsync: assert property (
    q.ctrl[IDX_A][TCS_BIT] && q.ctrl[IDX_A][SYNC_BIT] && runok[IDX_A]
    && (q.s2[IDX_A] ^ q.s3[IDX_A]) |-> tick[IDX_A])
    else $error("type a synchronised mode missed a divided edge");

  a_b_postsync: assert property (
    q.ctrl[IDX_B][TCS_BIT] && runok[IDX_B] && (q.s2[IDX_B] ^ q.s3[IDX_B])
    |-> tick[IDX_B])
    else $error("type b missed a synchronised divided edge");

  a_lpo_select: assert property (
    q.ctrl[IDX_A][LPO_BIT] && q.ctrl[IDX_A][TCS_BIT] && !q.ctrl[IDX_A][SYNC_BIT] && runok[IDX_A]
    && q.ctrl[IDX_A][PSC_HI:PSC_LO] == PSC_DIV1 && i_lposc_clk && !q.raw_q[IDX_A] |-> tick[IDX_A])
    else $error("type a missed a low-power oscillator edge");

  a_stop_psc: assert property (
    !runok[IDX_B] |=> q.psc[IDX_B] == 8'h00)
    else $error("prescaler not cleared while halted");

  a_flag_irq: assert property (
    o_irq == (q.iflag & q.ien))
    else $error("interrupt output differs from flag and enable");

  a_prio_write: assert property (
    i_wr && i_addr == reg_addr(IRQ_BASE, IDX_C)
    |=> q.iprio[IDX_C] == $past(i_wdata[PRIO_HI:PRIO_LO]))
    else $error("priority field not written");

  a_ctrl_mask: assert property (
    (q.ctrl[IDX_B] & ~CTL_MASK_B) == 16'h0000)
    else $error("unimplemented control bit set");

  a_rdata_idle: assert property (
    !$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data not zero outside a read");

  a_c_halt_pair: assert property (
    q.ctrl[IDX_B][PAIR_BIT] |-> !runok[IDX_C])
    else $error("type c ran on its own while paired");

  a_count_write: assert property (
    i_wr && i_addr == reg_addr(TMR_STRIDE * IDX_B, CNT_OFS)
    |=> q.count[IDX_B] == $past(i_wdata))
    else $error("count write did not land");

  a_gate_hold: assert property (
    runok[IDX_A] && !q.ctrl[IDX_A][TCS_BIT] && q.ctrl[IDX_A][GATE_BIT] && !raw[IDX_A] && !i_wr
    |=> $stable(q.count[IDX_A]))
    else $error("gated timer counted with its input low");

  a_adc_quiet: assert property (
    !match_c |=> !o_adc_trig)
    else $error("conversion trigger without a type c match");

endmodule
`default_nettype wire

/* verif/ext_clk_src.sv */
// partner: external count clocks and low-power oscillator, running only inside a frame
`timescale 1ns/10ps
`default_nettype none
module ext_clk_src #(
  parameter int HALF = 4
) (
  input wire logic i_clk,
  input wire logic i_en,
  output logic [2:0] o_ext_clk,
  output logic o_lposc_clk
);
  int cnt = 0;
  logic lvl = 1'b0;
  always @(posedge i_clk) begin
    if (!i_en) begin
      cnt <= 0;
      lvl <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      lvl <= ~lvl;
    end else begin
      cnt <= cnt + 1;
    end
  end
  assign o_ext_clk = {3{lvl}};
  assign o_lposc_clk = lvl;
endmodule
`default_nettype wire

/* verif/testbench.sv */
// testbench: register port, counting, prescaler, idle, external clocks, pairing and trigger
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import tmr_pkg::*;
  localparam int HALF = 4;
  logic i_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, i_idle = 0, en = 0;
  logic [4:0] i_addr = 5'h00;
  logic [15:0] i_wdata = 16'h0000, o_rdata, d;
  logic [2:0] o_irq, ext;
  logic [8:0] o_irq_prio;
  logic o_adc_trig, lpo;
  int n_fail = 0, check_count = 0, trig_n = 0;
  logic [15:0] masks [3] = '{CTL_MASK_A, CTL_MASK_B, CTL_MASK_C};
  tmr_family u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_idle(i_idle), .i_lposc_clk(lpo), .i_ext_clk(ext),
    .o_rdata(o_rdata), .o_irq(o_irq), .o_irq_prio(o_irq_prio), .o_adc_trig(o_adc_trig));
  ext_clk_src #(.HALF(HALF)) u_src (.i_clk(i_clk), .i_en(en), .o_ext_clk(ext),
    .o_lposc_clk(lpo));
  always #50 i_clk = ~i_clk;
  always @(posedge i_clk) if (o_adc_trig === 1'b1) trig_n <= trig_n + 1;
  ////////////////////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(int a, logic [15:0] v);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= 5'(a);
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rdchk(string name, int a, logic [15:0] exp);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= 5'(a);
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 check(name, o_rdata, exp);
  endtask
  // count k ticks of an internal clock
  task automatic run_for(int i, logic [15:0] ctl, int k);
    wr(3 * i + 2, ctl);
    repeat (k - 2) @(posedge i_clk);
    wr(3 * i + 2, 16'h0000);
  endtask
  task automatic prep(int i, logic [15:0] c, logic [15:0] p);
    wr(3 * i, c);
    wr(3 * i + 1, p);
  endtask
  task automatic frame(int n);
    @(posedge i_clk);
    en <= 1'b1;
    repeat ((2 * n - 1) * HALF) @(posedge i_clk);
    en <= 1'b0;
    repeat (10) @(posedge i_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    for (int a = 0; a < 12; a++) rdchk("reset", a, 16'h0000);
    check("irq", {13'h0, o_irq}, 16'h0000);
  endtask
  task automatic t_regs();
    for (int i = 0; i < 3; i++) begin
      prep(i, 16'ha5c3, 16'h5a3c);
      rdchk("period", 3 * i + 1, 16'h5a3c);
      wr(3 * i + 2, 16'hffff);
      rdchk("ctl", 3 * i + 2, masks[i]);
      wr(3 * i + 2, 16'h0000);
      prep(i, 16'ha5c3, 16'h5a3c);
      rdchk("count", 3 * i, 16'ha5c3);
      wr(IRQ_BASE + i, 16'hffff);
      rdchk("irqreg", IRQ_BASE + i, 16'h0073);
    end
    check("irq", {13'h0, o_irq}, 16'h0007);
    check("prio", {7'h0, o_irq_prio}, 16'h01ff);
    for (int i = 0; i < 3; i++) wr(IRQ_BASE + i, 16'h0000);
    wr(31, 16'hffff);
    rdchk("unmapped", 31, 16'h0000);
  endtask
  task automatic t_presc();
    for (int p = 0; p < 4; p++) begin
      prep(1, 16'h0000, 16'hffff);
      run_for(1, 16'h8000 | 16'(p << 4), 512);
      rdchk("presc", 3, 16'(512 >> (p == 3 ? 8 : 3 * p)));
    end
  endtask
  task automatic t_wrap();
    prep(0, 16'h0000, 16'h0003);
    wr(IRQ_BASE, 16'h0002);
    run_for(0, 16'h8000, 10);
    rdchk("wrap", 0, 16'h0002);
    check("irq", {13'h0, o_irq}, 16'h0001);
    rdchk("flag", IRQ_BASE, 16'h0003);
    wr(IRQ_BASE, 16'h0000);
  endtask
  task automatic t_idle();
    i_idle <= 1'b1;
    prep(0, 16'h0000, 16'hffff);
    run_for(0, 16'ha000, 8);
    rdchk("idle stop", 0, 16'h0000);
    run_for(0, 16'h8000, 8);
    rdchk("idle run", 0, 16'h0008);
    i_idle <= 1'b0;
  endtask
  task automatic t_ext(logic [15:0] ca, int n);
    for (int i = 0; i < 3; i++) prep(i, 16'h0000, 16'hffff);
    wr(2, ca);
    wr(5, 16'h8002);
    wr(8, 16'h8002);
    frame(n);
    for (int i = 0; i < 3; i++) wr(3 * i + 2, 16'h0000);
    rdchk("ext a", 0, 16'(n));
    rdchk("ext b", 3, 16'(n));
    rdchk("ext c", 6, 16'(n));
  endtask
  task automatic t_gate();
    prep(0, 16'h0000, 16'hffff);
    wr(2, 16'h8040);
    frame(3);
    wr(2, 16'h0000);
    rdchk("gate", 0, 16'(2 * HALF + 1));
  endtask
  task automatic t_pair();
    prep(1, 16'hfffe, 16'hffff);
    prep(2, 16'h0000, 16'hffff);
    run_for(1, 16'h8008, 4);
    rdchk("pair lo", 3, 16'h0002);
    rdchk("pair hi", 6, 16'h0001);
  endtask
  task automatic t_trig();
    prep(2, 16'h0000, 16'h0003);
    trig_n = 0;
    run_for(2, 16'h8000, 8);
    repeat (2) @(posedge i_clk);
    check("trig", 16'(trig_n), 16'h0002);
    rdchk("flag c", IRQ_BASE + 2, 16'h0001);
  endtask
  ////////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    #5ms;
    n_fail++;
    wrap_up();
  end
  initial begin
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    t_reset();
    t_regs();
    t_presc();
    t_wrap();
    t_idle();
    t_ext(16'h8006, 5);
    t_ext(16'h8002, 3);
    t_ext(16'h8003, 4);
    t_gate();
    t_pair();
    t_trig();
    wrap_up();
  end
endmodule
`default_nettype wire
